// file: core/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
	localparam int BUS_WIDTH = 16;

	// boot source, picked by the two select pins at power-up
	typedef enum logic [1:0] {
		BOOT_ROM      = 2'b00,
		BOOT_DSP      = 2'b01,
		BOOT_EPROM    = 2'b10,
		BOOT_PARALLEL = 2'b11
	} boot_source_t;

	typedef enum logic [1:0] {
		CFG_WAIT    = 2'b00,
		CFG_LOAD    = 2'b01,
		CFG_DONE    = 2'b10,
		CFG_PARTIAL = 2'b11
	} cfg_state_t;

	// pins that cross into the sys_clk domain together
	typedef struct packed {
		logic                 standby;
		logic                 filter_sync;
		logic                 restart_n;
		logic                 frame_sync;
		logic                 cs_n;
		logic                 read;
		logic                 reg_sel;
		logic [BUS_WIDTH-1:0] bus;
	} pin_sample_t;

	// word written by the host: instruction when is_instr
	typedef struct packed {
		logic                 is_instr;
		logic [BUS_WIDTH-1:0] data;
	} host_word_t;

	localparam int BOOT_SEL_HI_BIT = 15;
	localparam int BOOT_SEL_LO_BIT = 14;

	localparam int ROM_PULSE_CYCLES = 8;
	localparam logic [3:0] ROM_PULSE_LOAD = 4'h8;
	localparam logic [1:0] STRAP_SAMPLE_AT = 2'h2;

	localparam int INSTR_CONFIGURE = 0;
	localparam int INSTR_START     = 1;
	localparam int INSTR_STOP      = 2;

	localparam int STAT_LOW_POWER  = 0;
	localparam int STAT_CONFIGURED = 1;
	localparam int STAT_CONVERTING = 2;
	localparam int STAT_SETTLED    = 3;
	localparam int STAT_PARTIAL    = 4;
	localparam int STAT_WORD_READY = 5;
endpackage

// file: core/word_buffer.sv
`timescale 1ns/1ps
module word_buffer import adc_ctrl_pkg::*; #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
) (
	input  wire logic             sys_clk,
	input  wire logic             reset,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	initial begin
		if (DEPTH < 2 || WIDTH < 1)
			$error("word_buffer needs DEPTH >= 2 and WIDTH >= 1");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [CW-1:0]    count;
	logic [CW-1:0]    next_count;
	logic             push;
	logic             pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// head word sits in its own flop so the reader never sees a memory mux
	always_ff @(posedge sys_clk) begin
		if (reset)
			out_data <= '0;
		else if (pop && count > CW'(1))
			out_data <= mem[bump(rd_ptr)];
		else if (push && (count == '0 || (pop && count == CW'(1))))
			out_data <= in_data;
	end

	always_comb begin
		next_count = count;
		if (push && !pop)
			next_count = count + CW'(1);
		else if (pop && !push)
			next_count = count - CW'(1);
	end

	always_ff @(posedge sys_clk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// ready and valid are registered so both sides see flop outputs
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			if (push)
				wr_ptr <= bump(wr_ptr);
			if (pop)
				rd_ptr <= bump(rd_ptr);
			count <= next_count;
			in_ready <= (next_count != CW'(DEPTH));
			out_valid <= (next_count != '0);
		end
	end
endmodule

// file: core/adc_postproc_control_port.sv
`timescale 1ns/1ps
module adc_postproc_control_port import adc_ctrl_pkg::*; #(
	parameter int SEQ_WIDTH     = 8,
	parameter int SETTLE_CYCLES = 64,
	parameter int BUF_DEPTH     = 2
) (
	input  wire logic                 sys_clk,
	input  wire logic                 reset,
	input  wire logic                 low_power_request,
	input  wire logic                 filter_sync_request,
	input  wire logic                 config_restart_n,
	input  wire logic                 frame_sync_input,
	input  wire logic                 register_select,
	input  wire logic                 read_not_write,
	input  wire logic                 soe_cs_in,
	output logic                      serial_output_enable_irq,
	output logic                      soe_drive_n,
	input  wire logic [BUS_WIDTH-1:0] data_bus_in,
	output logic [BUS_WIDTH-1:0]      data_bus_out,
	output logic [BUS_WIDTH-1:0]      data_bus_drive_n,
	input  wire logic                 cfg_busy,
	input  wire logic                 cfg_success,
	input  wire logic                 cfg_error,
	output logic                      cfg_start,
	output boot_source_t              boot_source,
	output logic                      config_done_ok,
	output logic                      low_power,
	output logic                      core_reset,
	output logic                      conv_run,
	output logic [SEQ_WIDTH-1:0]      seq_count,
	output logic                      data_settled,
	input  wire logic                 conv_valid,
	input  wire logic [BUS_WIDTH-1:0] conv_data,
	output logic                      conv_ready,
	output logic                      serial_valid,
	output logic [BUS_WIDTH-1:0]      serial_word,
	input  wire logic                 serial_ready,
	output host_word_t                host_word,
	output logic                      host_word_valid
);
	localparam int SW = $clog2(SETTLE_CYCLES + 1);
	initial begin
		if (SEQ_WIDTH < 1 || SETTLE_CYCLES < 1 || BUF_DEPTH < 2)
			$error("adc_postproc_control_port: bad parameter");
	end

	pin_sample_t          pins_meta, pins, pins_prev;
	cfg_state_t           cfg_state;
	logic [1:0]           strap_count;
	logic [3:0]           rom_count;
	logic [SW-1:0]        settle_count;
	logic [BUS_WIDTH-1:0] status_word;
	logic                 strap_done, strap_pulse, run_cmd, dsp_irq, buf_pop, parallel;
	logic                 low_power_request_rise, low_power_request_fall, restart_fall, restart_rise, cs_fall, cs_rise;
	logic                 host_write, instr_write, cfg_ok, dsp_set, start_req;

	// the shared pin is a chip select input only in parallel mode
	assign parallel = strap_done && (boot_source == BOOT_PARALLEL);

	// first stage feeds only the second
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pins_meta <= '0;
			pins <= '0;
			pins_prev <= '0;
		end else begin
			pins_meta <= {low_power_request, filter_sync_request, config_restart_n, frame_sync_input,
				soe_cs_in, read_not_write, register_select, data_bus_in};
			pins <= pins_meta;
			pins_prev <= pins;
		end
	end

	assign low_power_request_rise = pins.standby && !pins_prev.standby;
	assign low_power_request_fall = !pins.standby && pins_prev.standby;
	assign restart_fall = !pins.restart_n && pins_prev.restart_n;
	assign restart_rise = pins.restart_n && !pins_prev.restart_n;
	assign cs_fall = parallel && !pins.cs_n && pins_prev.cs_n;
	assign cs_rise = parallel && pins.cs_n && !pins_prev.cs_n;
	assign host_write = cs_rise && !pins.read;
	assign instr_write = host_write && pins.reg_sel;
	assign cfg_ok = cfg_success && cfg_state == CFG_LOAD && !pins.standby;
	assign dsp_set = strap_pulse || restart_rise || cfg_ok;
	assign strap_pulse = !strap_done && strap_count == STRAP_SAMPLE_AT;

	always_comb begin
		start_req = 1'b0;
		if (parallel)
			start_req = instr_write && pins.bus[INSTR_CONFIGURE] && !pins.standby;
		else if (strap_pulse)
			start_req = !(pins.bus[BOOT_SEL_HI_BIT] && pins.bus[BOOT_SEL_LO_BIT]);
		else if (strap_done && restart_rise)
			start_req = 1'b1;
		else if (strap_done && low_power_request_fall && cfg_state == CFG_PARTIAL)
			start_req = 1'b1;
	end

	// select pins are caught once after power-on reset, never again
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			strap_count <= '0;
			strap_done <= 1'b0;
			boot_source <= BOOT_ROM;
		end else if (strap_pulse) begin
			strap_done <= 1'b1;
			boot_source <= boot_source_t'({pins.bus[BOOT_SEL_HI_BIT], pins.bus[BOOT_SEL_LO_BIT]});
		end else if (!strap_done) begin
			strap_count <= strap_count + 2'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cfg_state <= CFG_WAIT;
		end else if (low_power_request_rise && cfg_state == CFG_LOAD) begin
			cfg_state <= CFG_PARTIAL;
		end else if (restart_fall) begin
			cfg_state <= CFG_WAIT;
		end else begin
			case (cfg_state)
				CFG_WAIT: begin
					if (start_req)
						cfg_state <= CFG_LOAD;
				end
				CFG_LOAD: begin
					if (cfg_ok)
						cfg_state <= CFG_DONE;
					else if (cfg_error)
						cfg_state <= CFG_WAIT;
				end
				CFG_DONE: begin
					// standby leaves a finished load untouched
					if (start_req)
						cfg_state <= CFG_LOAD;
				end
				CFG_PARTIAL: begin
					if (start_req)
						cfg_state <= CFG_LOAD;
					else if (low_power_request_fall && parallel)
						cfg_state <= CFG_WAIT;
				end
				default: cfg_state <= CFG_WAIT;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cfg_start <= 1'b0;
			config_done_ok <= 1'b0;
		end else begin
			cfg_start <= start_req;
			config_done_ok <= !parallel && strap_done && cfg_state == CFG_DONE;
		end
	end

	// parallel mode needs a start instruction, and again after standby
	always_ff @(posedge sys_clk) begin
		if (reset || low_power_request_rise || cfg_state != CFG_DONE)
			run_cmd <= 1'b0;
		else if (instr_write && pins.bus[INSTR_STOP])
			run_cmd <= 1'b0;
		else if (instr_write && pins.bus[INSTR_START])
			run_cmd <= 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			low_power <= 1'b0;
			core_reset <= 1'b1;
			conv_run <= 1'b0;
		end else begin
			low_power <= pins.standby;
			core_reset <= pins.filter_sync || pins.standby;
			conv_run <= !pins.standby && cfg_state == CFG_DONE && (run_cmd || (strap_done && !parallel));
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset || pins.filter_sync)
			seq_count <= '0;
		else if (conv_run)
			seq_count <= seq_count + SEQ_WIDTH'(1);
	end

	// data flagged valid only once the filter has refilled
	always_ff @(posedge sys_clk) begin
		if (reset || pins.filter_sync || !conv_run) begin
			settle_count <= '0;
			data_settled <= 1'b0;
		end else if (settle_count != SW'(SETTLE_CYCLES)) begin
			settle_count <= settle_count + SW'(1);
		end else begin
			data_settled <= 1'b1;
		end
	end

	// set beats a frame sync in the same cycle
	always_ff @(posedge sys_clk) begin
		if (reset)
			dsp_irq <= 1'b0;
		else if (dsp_set)
			dsp_irq <= 1'b1;
		else if (pins.frame_sync)
			dsp_irq <= 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			rom_count <= '0;
		else if (cfg_ok && boot_source == BOOT_ROM)
			rom_count <= ROM_PULSE_LOAD;
		else if (rom_count != '0)
			rom_count <= rom_count - 4'h1;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			serial_output_enable_irq <= 1'b0;
			soe_drive_n <= 1'b1;
		end else begin
			soe_drive_n <= !strap_done || parallel;
			case (boot_source)
				BOOT_DSP: serial_output_enable_irq <= dsp_irq;
				BOOT_ROM: serial_output_enable_irq <= (rom_count != '0);
				BOOT_EPROM: serial_output_enable_irq <= !(cfg_state == CFG_LOAD || cfg_start);
				default: serial_output_enable_irq <= 1'b1;
			endcase
		end
	end

	always_comb begin
		status_word = '0;
		status_word[STAT_LOW_POWER] = low_power;
		status_word[STAT_CONFIGURED] = (cfg_state == CFG_DONE);
		status_word[STAT_CONVERTING] = conv_run;
		status_word[STAT_SETTLED] = data_settled;
		status_word[STAT_PARTIAL] = (cfg_state == CFG_PARTIAL);
		status_word[STAT_WORD_READY] = serial_valid;
	end

	// a conversion read takes the buffered word; status reads leave it
	assign buf_pop = parallel ? (cs_fall && pins.read && !pins.reg_sel) : serial_ready;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			data_bus_out <= '0;
			data_bus_drive_n <= '1;
		end else begin
			if (cs_fall && pins.read)
				data_bus_out <= pins.reg_sel ? status_word : serial_word;
			if (parallel && !pins.cs_n && pins.read)
				data_bus_drive_n <= '0;
			else
				data_bus_drive_n <= '1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			host_word <= '0;
			host_word_valid <= 1'b0;
		end else begin
			host_word_valid <= host_write;
			if (host_write)
				host_word <= {pins.reg_sel, pins.bus};
		end
	end
	word_buffer #(
		.WIDTH (BUS_WIDTH),
		.DEPTH (BUF_DEPTH)
	) u_result_buffer (
		.sys_clk   (sys_clk),
		.reset     (reset),
		.in_valid  (conv_valid && conv_run),
		.in_data   (conv_data),
		.in_ready  (conv_ready),
		.out_valid (serial_valid),
		.out_data  (serial_word),
		.out_ready (buf_pop)
	);

	chk_lp_entry: assert property (@(posedge sys_clk) disable iff (reset)
		$rose(pins.standby) |=> low_power ##0 !conv_run) else $error("standby not entered");
	chk_cfg_kept: assert property (@(posedge sys_clk) disable iff (reset)
		low_power_request_rise && cfg_state == CFG_DONE && !restart_fall |=> cfg_state == CFG_DONE)
		else $error("configuration lost in standby");
	chk_partial_restart: assert property (@(posedge sys_clk) disable iff (reset)
		low_power_request_fall && cfg_state == CFG_PARTIAL && !parallel && strap_done |=> cfg_start ##0 cfg_state == CFG_LOAD)
		else $error("partial load not restarted");
	chk_sync_hold: assert property (@(posedge sys_clk) disable iff (reset)
		pins.filter_sync |=> seq_count == '0 && core_reset) else $error("sync did not hold sequencer");
	chk_settle_gap: assert property (@(posedge sys_clk) disable iff (reset)
		$fell(data_settled) |-> !data_settled [*8]) else $error("settled flag too early");
	chk_eprom_enable: assert property (@(posedge sys_clk) disable iff (reset)
		boot_source == BOOT_EPROM && cfg_state == CFG_LOAD |=> !serial_output_enable_irq)
		else $error("eprom not enabled while loading");
	chk_dsp_irq_set: assert property (@(posedge sys_clk) disable iff (reset)
		boot_source == BOOT_DSP && cfg_ok |=> ##1 serial_output_enable_irq)
		else $error("dsp interrupt missing after load");
	chk_fsi_clear: assert property (@(posedge sys_clk) disable iff (reset)
		pins.frame_sync && !dsp_set |=> !dsp_irq) else $error("frame sync did not clear interrupt");
	chk_rom_pulse: assert property (@(posedge sys_clk) disable iff (reset)
		boot_source == BOOT_ROM && cfg_ok ##1 !cfg_ok [*8] |-> !$past(serial_output_enable_irq, 7) &&
		$past(serial_output_enable_irq, 6) && serial_output_enable_irq ##1 serial_output_enable_irq
		##1 !serial_output_enable_irq)
		else $error("rom pulse not eight cycles");
	chk_read_drive: assert property (@(posedge sys_clk) disable iff (reset)
		cs_fall && pins.read |=> data_bus_drive_n == '0 ##0 data_bus_out == $past(pins.reg_sel ? status_word : serial_word))
		else $error("read did not drive bus");
	chk_write_capture: assert property (@(posedge sys_clk) disable iff (reset)
		host_write |=> host_word_valid && host_word.data == $past(pins.bus)) else $error("write not captured");
	chk_strap_stable: assert property (@(posedge sys_clk) disable iff (reset)
		strap_done |=> $stable(boot_source)) else $error("boot source changed after power-up");
	chk_bus_release: assert property (@(posedge sys_clk) disable iff (reset)
		pins.cs_n |=> data_bus_drive_n == '1) else $error("bus driven with chip select high");
endmodule

// file: tb/loader_model.sv
`timescale 1ns/1ps
module loader_model import adc_ctrl_pkg::*; #(
	parameter int LOAD_CYCLES = 20
) (
	input  wire logic            sys_clk,
	input  wire logic            reset,
	input  wire logic            cfg_start,
	input  wire logic            conv_run,
	input  wire logic            conv_ready,
	output logic                 cfg_busy,
	output logic                 cfg_success,
	output logic                 cfg_error,
	output logic                 conv_valid,
	output logic [BUS_WIDTH-1:0] conv_data,
	output logic [7:0]           n_starts
);
	int cnt;

	// a new start restarts the download from its first word, as a reset eprom address would
	always_ff @(posedge sys_clk) begin
		cfg_success <= 1'b0;
		cfg_error <= 1'b0;
		if (reset) begin
			cnt <= 0;
			cfg_busy <= 1'b0;
			n_starts <= 8'h00;
		end else if (cfg_start) begin
			cnt <= LOAD_CYCLES;
			cfg_busy <= 1'b1;
			n_starts <= n_starts + 8'h01;
		end else if (cnt == 1) begin
			cnt <= 0;
			cfg_busy <= 1'b0;
			cfg_success <= 1'b1;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end

	// results step only on an accepted word, so a lost word shows as a gap in the stream
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			conv_data <= 16'h0000;
		end else if (conv_valid && conv_ready && conv_run) begin
			conv_data <= conv_data + 16'h0001;
		end
	end

	assign conv_valid = !reset;
endmodule

// file: tb/adc_postproc_control_port_bench.sv
`timescale 1ns/1ps
module adc_postproc_control_port_bench import adc_ctrl_pkg::*;;
	logic                 sys_clk, reset, low_power_request, filter_sync_request, config_restart_n;
	logic                 frame_sync_input, register_select, read_not_write, soe_cs_in, serial_ready;
	logic [BUS_WIDTH-1:0] data_bus_in, data_bus_out, data_bus_drive_n, conv_data, serial_word, w, v, prev;
	logic                 serial_output_enable_irq, soe_drive_n, cfg_busy, cfg_success, cfg_error, cfg_start;
	logic                 config_done_ok, low_power, core_reset, conv_run, data_settled, conv_valid, conv_ready;
	logic                 serial_valid, host_word_valid;
	logic [7:0]           seq_count, n_starts;
	boot_source_t         boot_source;
	host_word_t           host_word;
	int                   mismatches, n_checks, cycles, cnt;

	adc_postproc_control_port #(.SEQ_WIDTH(8), .SETTLE_CYCLES(8), .BUF_DEPTH(2)) uut (
		.sys_clk(sys_clk), .reset(reset), .low_power_request(low_power_request),
		.filter_sync_request(filter_sync_request), .config_restart_n(config_restart_n),
		.frame_sync_input(frame_sync_input), .register_select(register_select), .read_not_write(read_not_write),
		.soe_cs_in(soe_cs_in), .serial_output_enable_irq(serial_output_enable_irq), .soe_drive_n(soe_drive_n),
		.data_bus_in(data_bus_in), .data_bus_out(data_bus_out), .data_bus_drive_n(data_bus_drive_n),
		.cfg_busy(cfg_busy), .cfg_success(cfg_success), .cfg_error(cfg_error), .cfg_start(cfg_start),
		.boot_source(boot_source), .config_done_ok(config_done_ok), .low_power(low_power),
		.core_reset(core_reset), .conv_run(conv_run), .seq_count(seq_count), .data_settled(data_settled),
		.conv_valid(conv_valid), .conv_data(conv_data), .conv_ready(conv_ready), .serial_valid(serial_valid),
		.serial_word(serial_word), .serial_ready(serial_ready), .host_word(host_word),
		.host_word_valid(host_word_valid));

	loader_model #(.LOAD_CYCLES(20)) far_end (
		.sys_clk(sys_clk), .reset(reset), .cfg_start(cfg_start), .conv_run(conv_run), .conv_ready(conv_ready),
		.cfg_busy(cfg_busy), .cfg_success(cfg_success), .cfg_error(cfg_error), .conv_valid(conv_valid),
		.conv_data(conv_data), .n_starts(n_starts));

	// clock never pauses, standby included
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task tick(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// 0: host word pulse, 1: settled flag; bounded so a dead design cannot hang the run
	task wait_sel(input int which);
		int i;
		for (i = 0; i < 200; i++) begin
			if (which == 0 && host_word_valid === 1'b1) return;
			if (which == 1 && data_settled === 1'b1) return;
			tick(1);
		end
		chk(32'h0, 32'h1);
	endtask

	// straps ride on the bus msbs and are held well past their sampling edge
	task powerup(input logic [1:0] strap);
		reset = 1'b1;
		data_bus_in = {strap, 14'h0000};
		tick(16);
		reset = 1'b0;
		tick(6);
		data_bus_in = 16'h0000;
	endtask

	// data held across the chip select rise until the word is seen
	task pwrite(input logic rs, input logic [15:0] d);
		read_not_write = 1'b0;
		register_select = rs;
		data_bus_in = d;
		soe_cs_in = 1'b0;
		tick(4);
		soe_cs_in = 1'b1;
		wait_sel(0);
		tick(2);
	endtask

	task pread(input logic rs, output logic [15:0] d);
		read_not_write = 1'b1;
		register_select = rs;
		soe_cs_in = 1'b0;
		tick(5);
		chk(data_bus_drive_n, 16'h0000);
		d = data_bus_out;
		soe_cs_in = 1'b1;
		tick(5);
		chk(data_bus_drive_n, 16'hffff);
	endtask

	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 6000) begin
			mismatches++;
			wrap_up();
		end
	end

	initial begin
		{reset, config_restart_n, read_not_write, soe_cs_in, serial_ready} = 5'h1f;
		{low_power_request, filter_sync_request, frame_sync_input, register_select} = 4'h0;
		data_bus_in = 16'h0000;
		powerup(2'b00);
		chk(boot_source, BOOT_ROM);
		cnt = 0;
		repeat (60) begin
			tick(1);
			if (serial_output_enable_irq === 1'b1) cnt++;
		end
		chk(cnt, 8);
		chk(config_done_ok, 1'b1);
		data_bus_in = 16'hc000;
		tick(10);
		chk(boot_source, BOOT_ROM);
		data_bus_in = 16'h0000;
		serial_ready = 1'b0;
		tick(10);
		chk(conv_ready, 1'b0);
		low_power_request = 1'b1;
		tick(10);
		chk({low_power, conv_run}, 2'b10);
		chk(config_done_ok, 1'b1);
		low_power_request = 1'b0;
		tick(6);
		chk({low_power, conv_run}, 2'b01);
		serial_ready = 1'b1;
		cnt = 0;
		repeat (12) begin
			if (serial_valid === 1'b1) begin
				if (cnt > 0) chk(serial_word, prev + 16'h0001);
				prev = serial_word;
				cnt++;
			end
			tick(1);
		end
		chk(cnt > 4, 1'b1);
		filter_sync_request = 1'b1; // single pulse, never a train
		tick(8);
		chk({core_reset, seq_count}, 9'h100);
		filter_sync_request = 1'b0;
		tick(5);
		chk({core_reset, data_settled}, 2'b00);
		wait_sel(1);
		$display("test rom done");

		powerup(2'b01);
		chk({serial_output_enable_irq, soe_drive_n}, 2'b10);
		frame_sync_input = 1'b1;
		tick(1);
		frame_sync_input = 1'b0;
		tick(5);
		chk(serial_output_enable_irq, 1'b0);
		tick(30);
		chk({config_done_ok, serial_output_enable_irq}, 2'b11);
		frame_sync_input = 1'b1;
		tick(1);
		frame_sync_input = 1'b0;
		tick(5);
		chk(serial_output_enable_irq, 1'b0);
		config_restart_n = 1'b0;
		tick(3);
		config_restart_n = 1'b1;
		tick(6);
		chk({serial_output_enable_irq, n_starts}, 9'h102);
		$display("test dsp done");

		powerup(2'b10);
		chk({serial_output_enable_irq, soe_drive_n}, 2'b00);
		low_power_request = 1'b1;
		tick(30);
		chk(config_done_ok, 1'b0);
		low_power_request = 1'b0;
		tick(10);
		chk({serial_output_enable_irq, n_starts}, 9'h002);
		tick(30);
		chk({config_done_ok, serial_output_enable_irq}, 2'b11);
		$display("test eprom done");

		powerup(2'b11);
		chk(boot_source, BOOT_PARALLEL);
		chk({soe_drive_n, data_bus_drive_n, n_starts}, 25'h1ffff00);
		pwrite(1'b1, 16'h0001);
		chk(host_word, {1'b1, 16'h0001});
		tick(1);
		chk(n_starts, 8'h01);
		tick(30);
		pread(1'b1, w);
		chk(w[1], 1'b1);
		pwrite(1'b0, 16'h8000);
		chk(host_word, {1'b0, 16'h8000});
		pwrite(1'b1, 16'h0002);
		tick(4);
		chk(conv_run, 1'b1);
		tick(6);
		pread(1'b0, w);
		pread(1'b0, v);
		chk(v, w + 16'h0001);
		pwrite(1'b1, 16'h0004);
		chk(conv_run, 1'b0);
		// standby lands in mid-load, so the parallel host must configure again
		pwrite(1'b1, 16'h0001);
		low_power_request = 1'b1;
		tick(30);
		low_power_request = 1'b0;
		tick(40);
		chk({n_starts, conv_run}, 9'h004);
		pwrite(1'b1, 16'h0001);
		tick(1);
		chk(n_starts, 8'h03);
		$display("test parallel done");
		wrap_up();
	end
endmodule
